// ==== logic/scl_map.svh ====
// Offsets, field positions, reset values and clock frequencies of the strap loader.
// Assumes inclusion by bare name from the design modules.
//
// Operation
// - Straps are sampled only during reset and held until the next reset.
// - Strap pins float as pulled inputs in reset, then drive their function.
// - Code 100 gives preamble-restore MII, 110 back-to-back; codes other than these and 000 are reserved.
// - Detach strap is copied into control bit 10; high enables detach.
// - Speed strap is copied into control bit 13; high means 100 Mbps.
// - Speed strap also sets the advertised speed abilities.
// - Duplex strap goes into control bit 8; high means half duplex.
// - Negotiation strap goes into control bit 12; high enables negotiation.
// - Negotiation off means running at the control-register speed and duplex.
// - MII modes time everything from the 25 MHz reference.
// - Reduced and serial modes use 50 MHz and 125 MHz references.
// - The synthesizer derives 125, 25 and 20 MHz clocks from the reference.
// - Interface code 000 selects standard MII, the default.
// - Station address takes three strap bits; upper two are zero.
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

`define SCL_OFS_CTRL     8'h00
`define SCL_OFS_ADV      8'h04
`define SCL_OFS_STRAP    8'h08
`define SCL_OFS_CLK      8'h0c

`define SCL_CTRL_SPEED   13
`define SCL_CTRL_AN      12
`define SCL_CTRL_ISO     10
`define SCL_CTRL_DUP     8
`define SCL_CTRL_WMASK   16'h3500
`define SCL_CTRL_RST     16'h3100

`define SCL_ADV_100FD    8
`define SCL_ADV_100HD    7
`define SCL_ADV_WMASK    16'h01e0
`define SCL_ADV_RST      16'h01e1
`define SCL_ADV_10ONLY   16'h0061

`define SCL_PIN_ID0      0
`define SCL_PIN_CFG0     3
`define SCL_PIN_ISO      6
`define SCL_PIN_SPD      7
`define SCL_PIN_DUP      8
`define SCL_PIN_AN       9
`define SCL_PULL_UP      10'h381
`define SCL_STATION_RST  5'h01

`define SCL_CFG_MII      3'h0
`define SCL_CFG_PRE      3'h4
`define SCL_CFG_B2B      3'h6
`define SCL_FAM_MII      2'h0
`define SCL_FAM_RMII     2'h1
`define SCL_FAM_SMII     2'h2

`define SCL_REF_MII_MHZ  25
`define SCL_REF_RMII_MHZ 50
`define SCL_REF_SMII_MHZ 125
`define SCL_VCO_MHZ      500
`define SCL_OUT_A_MHZ    125
`define SCL_OUT_B_MHZ    25
`define SCL_OUT_C_MHZ    20

`endif

// ==== logic/scl_pkg.sv ====
// Types shared by the strap loader and its clock selector.
// Assumes the map header sits beside it.
package scl_pkg;
	typedef enum logic [5:0] {
		SCL_MODE_MII  = 6'h01,
		SCL_MODE_PRE  = 6'h02,
		SCL_MODE_B2B  = 6'h04,
		SCL_MODE_RMII = 6'h08,
		SCL_MODE_SMII = 6'h10,
		SCL_MODE_RSVD = 6'h20
	} scl_mode_t;
	typedef enum logic [1:0] {
		SCL_PH_HOLD = 2'h1,
		SCL_PH_RUN  = 2'h2
	} scl_phase_t;
	typedef enum logic [2:0] {
		SCL_REF_25  = 3'h1,
		SCL_REF_50  = 3'h2,
		SCL_REF_125 = 3'h4
	} scl_ref_t;
endpackage : scl_pkg

// ==== logic/scl_clk_if.sv ====
// Carries the interface mode to the clock selector and its answer back.
// Assumes scl_pkg is compiled first.
`timescale 1ns/1ns
interface scl_clk_if;
	import scl_pkg::*;
	scl_mode_t  mode;
	scl_ref_t   ref_sel;
	logic [7:0] mult;
	logic [7:0] div_a;
	logic [7:0] div_b;
	logic [7:0] div_c;
	modport src (output mode, input ref_sel, mult, div_a, div_b, div_c);
	modport sel (input mode, output ref_sel, mult, div_a, div_b, div_c);
endinterface : scl_clk_if

// ==== logic/scl_clk_sel.sv ====
// Chooses the reference clock and synthesizer ratios for an interface mode.
// Assumes a 500 MHz internal oscillator that divides down to each output.
`timescale 1ns/1ns
`include "scl_map.svh"
module scl_clk_sel
	import scl_pkg::*;
(
	scl_clk_if.sel cif
);
	function automatic logic [7:0] ratio(input int num, input int den);
		ratio = 8'(num / den);
	endfunction : ratio

	int ref_mhz;

	always_comb begin
		ref_mhz = `SCL_REF_MII_MHZ;
		case (cif.mode)
			SCL_MODE_RMII: begin
				ref_mhz = `SCL_REF_RMII_MHZ;
			end
			SCL_MODE_SMII: begin
				ref_mhz = `SCL_REF_SMII_MHZ;
			end
			default: begin
				ref_mhz = `SCL_REF_MII_MHZ;
			end
		endcase
	end

	assign cif.ref_sel = (ref_mhz == `SCL_REF_RMII_MHZ) ? SCL_REF_50 :
		(ref_mhz == `SCL_REF_SMII_MHZ) ? SCL_REF_125 : SCL_REF_25;
	// The oscillator multiplier follows the reference; the output dividers stay fixed.
	assign cif.mult  = ratio(`SCL_VCO_MHZ, ref_mhz);
	assign cif.div_a = ratio(`SCL_VCO_MHZ, `SCL_OUT_A_MHZ);
	assign cif.div_b = ratio(`SCL_VCO_MHZ, `SCL_OUT_B_MHZ);
	assign cif.div_c = ratio(`SCL_VCO_MHZ, `SCL_OUT_C_MHZ);
endmodule : scl_clk_sel

// ==== logic/strap_config_latch.sv ====
// Strap sampler, configuration registers and clock selection of the PHY.
// Assumes strap inputs and the register port are synchronous to core_clk,
// and that core_clk runs while reset is held low.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "scl_map.svh"
module strap_config_latch
	import scl_pkg::*;
#(
	parameter int PIN_W  = 10,
	parameter int DATA_W = 16,
	parameter int ADDR_W = 8
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic [PIN_W-1:0]  strap_in,
	input  wire logic [PIN_W-1:0]  func_out,
	output logic      [PIN_W-1:0]  pin_out,
	output logic      [PIN_W-1:0]  pin_oe_n,
	output logic      [PIN_W-1:0]  pull_en,
	output logic      [PIN_W-1:0]  pull_up,
	input  wire logic [1:0]        ifc_family,
	input  wire logic              an_done,
	input  wire logic              an_speed,
	input  wire logic              an_duplex,
	output logic      [4:0]        station_addr,
	output scl_mode_t              if_mode,
	output logic                   cfg_reserved,
	output logic                   isolate,
	output logic                   an_enable,
	output logic                   op_speed,
	output logic                   op_duplex,
	output scl_ref_t               ref_sel,
	output logic      [7:0]        pll_mult,
	output logic      [7:0]        div_125,
	output logic      [7:0]        div_25,
	output logic      [7:0]        div_20,
	output logic                   straps_loaded
);
	localparam logic [DATA_W-1:0] CTRL_RST  = DATA_W'(`SCL_CTRL_RST);
	localparam logic [DATA_W-1:0] CTRL_MASK = DATA_W'(`SCL_CTRL_WMASK);
	localparam logic [DATA_W-1:0] ADV_RST   = DATA_W'(`SCL_ADV_RST);
	localparam logic [DATA_W-1:0] ADV_MASK  = DATA_W'(`SCL_ADV_WMASK);
	localparam logic [DATA_W-1:0] ADV_10    = DATA_W'(`SCL_ADV_10ONLY);
	localparam logic [PIN_W-1:0]  PULL_UP   = PIN_W'(`SCL_PULL_UP);

	// Merges write data into a register through its writable-bit mask.
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [DATA_W-1:0] mask
	);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction : merge

	// Compares a bus address with a register offset at the bus width.
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] a,
		input logic [7:0]        ofs
	);
		addr_hit = (a == ADDR_W'(ofs));
	endfunction : addr_hit

	// Maps a strapped interface code and the bonding family onto a mode.
	function automatic scl_mode_t decode_mode(
		input logic [2:0] code,
		input logic [1:0] fam
	);
		scl_mode_t m;
		m = SCL_MODE_RSVD;
		if (fam == `SCL_FAM_RMII) begin
			m = SCL_MODE_RMII;
		end else if (fam == `SCL_FAM_SMII) begin
			m = SCL_MODE_SMII;
		end else begin
			case (code)
				`SCL_CFG_MII: begin
					m = SCL_MODE_MII;
				end
				`SCL_CFG_PRE: begin
					m = SCL_MODE_PRE;
				end
				`SCL_CFG_B2B: begin
					m = SCL_MODE_B2B;
				end
				default: begin
					m = SCL_MODE_RSVD;
				end
			endcase
		end
		decode_mode = m;
	endfunction : decode_mode

	scl_phase_t        phase_q;
	scl_phase_t        phase_d;
	logic [PIN_W-1:0]  samp_q;
	logic [1:0]        fam_q;
	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] ctrl_d;
	logic [DATA_W-1:0] adv_q;
	logic [DATA_W-1:0] adv_d;
	logic [2:0]        cfg_code_q;
	logic [4:0]        station_q;
	scl_mode_t         mode_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [PIN_W-1:0]  pin_out_q;
	logic [PIN_W-1:0]  oe_n_q;
	logic [PIN_W-1:0]  pull_en_q;
	logic              op_speed_q;
	logic              op_duplex_q;
	scl_ref_t          ref_q;
	logic [7:0]        mult_q;
	logic [7:0]        div_a_q;
	logic [7:0]        div_b_q;
	logic [7:0]        div_c_q;
	logic [2:0]        cfg_code_d;
	logic [4:0]        station_d;
	scl_mode_t         mode_d;
	logic              reserved_q;
	logic              reserved_d;
	logic              loaded_q;
	logic [PIN_W-1:0]  pull_up_q;
	logic [PIN_W-1:0]  samp_d;
	logic [1:0]        fam_d;
	logic              op_speed_d;
	logic              op_duplex_d;
	logic [DATA_W-1:0] ctrl_wr_v;
	logic [DATA_W-1:0] adv_wr_v;

	// Control bits are only meaningful after the straps have been loaded.
	logic              load_now;
	logic              hit_ctrl;
	logic              hit_adv;
	logic              hit_strap;
	logic              hit_clk;
	logic              wr_ctrl;
	logic              wr_adv;
	logic [2:0]        samp_cfg;
	logic [2:0]        samp_id;
	logic              samp_iso;
	logic              samp_spd;
	logic              samp_dup;
	logic              samp_an;
	logic [DATA_W-1:0] ctrl_load;
	logic [DATA_W-1:0] adv_load;
	logic [DATA_W-1:0] strap_view;
	logic [DATA_W-1:0] clk_view;
	logic              cur_an;
	logic              cur_spd;
	logic              cur_dup;
	scl_mode_t         mode_new;

	scl_clk_if cif ();

	scl_clk_sel u_clk_sel (
		.cif (cif.sel)
	);

	assign load_now  = (phase_q == SCL_PH_HOLD);
	assign phase_d   = SCL_PH_RUN;

	assign samp_cfg  = samp_q[`SCL_PIN_CFG0 +: 3];
	assign samp_id   = samp_q[`SCL_PIN_ID0 +: 3];
	assign samp_iso  = samp_q[`SCL_PIN_ISO];
	assign samp_spd  = samp_q[`SCL_PIN_SPD];
	assign samp_dup  = samp_q[`SCL_PIN_DUP];
	assign samp_an   = samp_q[`SCL_PIN_AN];

	always_comb begin
		ctrl_load                  = CTRL_RST & ~CTRL_MASK;
		ctrl_load[`SCL_CTRL_ISO]   = samp_iso;
		ctrl_load[`SCL_CTRL_SPEED] = samp_spd;
		ctrl_load[`SCL_CTRL_DUP]   = samp_dup;
		ctrl_load[`SCL_CTRL_AN]    = samp_an;
	end

	// A 10 Mbps strap withdraws both 100 Mbps abilities from the advertisement.
	assign adv_load  = samp_spd ? ADV_RST : ADV_10;

	assign mode_new  = decode_mode(samp_cfg, fam_q);
	assign cif.mode  = mode_q;

	assign hit_ctrl  = addr_hit(reg_addr, `SCL_OFS_CTRL);
	assign hit_adv   = addr_hit(reg_addr, `SCL_OFS_ADV);
	assign hit_strap = addr_hit(reg_addr, `SCL_OFS_STRAP);
	assign hit_clk   = addr_hit(reg_addr, `SCL_OFS_CLK);
	assign wr_ctrl   = reg_wr && hit_ctrl;
	assign wr_adv    = reg_wr && hit_adv;

	// Loading wins over a write that lands on the same edge.
	assign ctrl_wr_v = merge(ctrl_q, reg_wdata, CTRL_MASK);
	assign adv_wr_v  = merge(adv_q, reg_wdata, ADV_MASK);
	assign ctrl_d = load_now ? ctrl_load :
		wr_ctrl ? ctrl_wr_v : ctrl_q;
	assign adv_d  = load_now ? adv_load :
		wr_adv ? adv_wr_v : adv_q;

	assign strap_view = DATA_W'({straps_loaded, cfg_reserved, station_q,
		cfg_code_q});
	assign clk_view = DATA_W'({mult_q, 5'h0, ref_q});

	// No read, or a read of an unmapped offset, returns zero.
	assign rdata_d = !reg_rd ? '0 :
		hit_ctrl  ? ctrl_q :
		hit_adv   ? adv_q :
		hit_strap ? strap_view :
		hit_clk   ? clk_view : '0;

	assign cur_an  = ctrl_q[`SCL_CTRL_AN];
	assign cur_spd = ctrl_q[`SCL_CTRL_SPEED];
	assign cur_dup = ctrl_q[`SCL_CTRL_DUP];

	// Pins are tracked on every edge with reset low and frozen once it rises.
	assign samp_d = !rstn ? strap_in : samp_q;
	assign fam_d  = !rstn ? ifc_family : fam_q;

	// Identity fields change only on the load edge after reset.
	assign cfg_code_d = load_now ? samp_cfg : cfg_code_q;
	assign station_d  = load_now ? {2'h0, samp_id} : station_q;
	assign mode_d     = load_now ? mode_new : mode_q;
	assign reserved_d = load_now ? (mode_new == SCL_MODE_RSVD) :
		reserved_q;

	// With negotiation off the link runs at the control-register settings.
	assign op_speed_d  = !cur_an ? cur_spd :
		an_done ? an_speed : op_speed_q;
	assign op_duplex_d = !cur_an ? cur_dup :
		an_done ? an_duplex : op_duplex_q;

	// Sampler keeps no reset so it can follow the pins while reset is low.
	always_ff @(posedge core_clk) begin
		samp_q <= samp_d;
		fam_q  <= fam_d;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			phase_q  <= SCL_PH_HOLD;
			loaded_q <= 1'b0;
		end else begin
			phase_q  <= phase_d;
			loaded_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
			adv_q  <= ADV_RST;
		end else begin
			ctrl_q <= ctrl_d;
			adv_q  <= adv_d;
		end
	end

	// Strapped identity is held for the whole run; only reset reloads it.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_code_q <= `SCL_CFG_MII;
			station_q  <= `SCL_STATION_RST;
			mode_q     <= SCL_MODE_MII;
			reserved_q <= 1'b0;
		end else begin
			cfg_code_q <= cfg_code_d;
			station_q  <= station_d;
			mode_q     <= mode_d;
			reserved_q <= reserved_d;
		end
	end

	// Pins stay released with their pulls on until the straps are loaded.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			oe_n_q    <= '1;
			pull_en_q <= '1;
			pin_out_q <= '0;
			pull_up_q <= PULL_UP;
		end else begin
			oe_n_q    <= '0;
			pull_en_q <= '0;
			pin_out_q <= func_out;
			pull_up_q <= PULL_UP;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			op_speed_q  <= 1'b1;
			op_duplex_q <= 1'b1;
		end else begin
			op_speed_q  <= op_speed_d;
			op_duplex_q <= op_duplex_d;
		end
	end

	// The clock choice trails the loaded mode by one edge.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ref_q   <= SCL_REF_25;
			mult_q  <= '0;
			div_a_q <= '0;
			div_b_q <= '0;
			div_c_q <= '0;
		end else begin
			ref_q   <= cif.ref_sel;
			mult_q  <= cif.mult;
			div_a_q <= cif.div_a;
			div_b_q <= cif.div_b;
			div_c_q <= cif.div_c;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata     = rdata_q;
	assign pin_out       = pin_out_q;
	assign pin_oe_n      = oe_n_q;
	assign pull_en       = pull_en_q;
	assign pull_up       = pull_up_q;
	assign station_addr  = station_q;
	assign if_mode       = mode_q;
	assign cfg_reserved  = reserved_q;
	assign isolate       = ctrl_q[`SCL_CTRL_ISO];
	assign an_enable     = cur_an;
	assign op_speed      = op_speed_q;
	assign op_duplex     = op_duplex_q;
	assign ref_sel       = ref_q;
	assign pll_mult      = mult_q;
	assign div_125       = div_a_q;
	assign div_25        = div_b_q;
	assign div_20        = div_c_q;
	assign straps_loaded = loaded_q;
endmodule : strap_config_latch

// ==== verification/scl_properties.sv ====
// Port-level assertions for the strap loader, bound into every instance.
// Assumes scl_pkg is compiled first and a single clock domain.
`timescale 1ns/1ns
module scl_checker
	import scl_pkg::*;
#(
	parameter int PIN_W  = 10,
	parameter int DATA_W = 16
) (
	input wire logic              core_clk,
	input wire logic              rstn,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [PIN_W-1:0]  func_out,
	input wire logic [PIN_W-1:0]  pin_out,
	input wire logic [PIN_W-1:0]  pin_oe_n,
	input wire logic [PIN_W-1:0]  pull_en,
	input wire logic [4:0]        station_addr,
	input wire scl_mode_t         if_mode,
	input wire logic              cfg_reserved,
	input wire scl_ref_t          ref_sel,
	input wire logic [7:0]        pll_mult,
	input wire logic [7:0]        div_125,
	input wire logic [7:0]        div_25,
	input wire logic [7:0]        div_20,
	input wire logic              straps_loaded
);
	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	a_pins_released: assert property (
		straps_loaded |-> pin_oe_n == '0 && pull_en == '0)
		else $error("pins still released after load");
	a_pin_follow: assert property (
		straps_loaded && $past(straps_loaded) |-> pin_out == $past(func_out))
		else $error("pin output does not follow function");
	a_mode_hold: assert property (
		straps_loaded |=> $stable(if_mode) && $stable(station_addr))
		else $error("latched mode changed outside reset");
	a_station_top: assert property (
		station_addr[4:3] == 2'b00)
		else $error("station upper bits not zero");
	a_reserved_flag: assert property (
		cfg_reserved == (if_mode == SCL_MODE_RSVD))
		else $error("reserved flag disagrees with mode");
	a_ref_mii: assert property (
		straps_loaded && $past(straps_loaded) && !(if_mode inside
		{SCL_MODE_RMII, SCL_MODE_SMII}) |-> ref_sel == SCL_REF_25
		&& pll_mult == 8'h14)
		else $error("mii family not on 25 MHz reference");
	a_ref_rmii: assert property (
		straps_loaded && $past(straps_loaded) && if_mode == SCL_MODE_RMII
		|-> ref_sel == SCL_REF_50 && pll_mult == 8'h0a)
		else $error("reduced mode not on 50 MHz reference");
	a_ref_smii: assert property (
		straps_loaded && $past(straps_loaded) && if_mode == SCL_MODE_SMII
		|-> ref_sel == SCL_REF_125 && pll_mult == 8'h04)
		else $error("serial mode not on 125 MHz reference");
	a_synth_div: assert property (
		straps_loaded |-> div_125 == 8'h04 && div_25 == 8'h14
		&& div_20 == 8'h19)
		else $error("synthesizer divider wrong");
	a_read_pulse: assert property (
		!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its cycle");
	c_loaded: cover property ($rose(straps_loaded));
	c_smii: cover property (if_mode == SCL_MODE_SMII);
	c_read: cover property (reg_rd ##1 reg_rdata != '0);
endmodule : scl_checker
bind strap_config_latch scl_checker #(.PIN_W(PIN_W), .DATA_W(DATA_W)) u_chk (
	.core_clk, .rstn, .reg_rd, .reg_rdata, .func_out, .pin_out, .pin_oe_n,
	.pull_en, .station_addr, .if_mode, .cfg_reserved, .ref_sel, .pll_mult,
	.div_125, .div_25, .div_20, .straps_loaded);

// ==== verification/scl_strap_board.sv ====
// Board side of the strap pins: fitted resistors and the shared wire level.
// Assumes the device's split pin signals are fed in unchanged.
`timescale 1ns/1ns
module scl_strap_board #(
	parameter int PIN_W = 10
) (
	input  wire logic [PIN_W-1:0] board,
	input  wire logic [PIN_W-1:0] fitted,
	input  wire logic [PIN_W-1:0] pin_out,
	input  wire logic [PIN_W-1:0] pin_oe_n,
	input  wire logic [PIN_W-1:0] pull_en,
	input  wire logic [PIN_W-1:0] pull_up,
	output logic      [PIN_W-1:0] pin_lvl
);
	// Resistors only pull; nothing here drives a pin high in reset.
	always_comb begin
		for (int i = 0; i < PIN_W; i++) begin
			if (!pin_oe_n[i])
				pin_lvl[i] = pin_out[i];
			else if (fitted[i])
				pin_lvl[i] = board[i];
			else if (pull_en[i])
				pin_lvl[i] = pull_up[i];
			else
				pin_lvl[i] = ~pin_out[i];
		end
	end
endmodule : scl_strap_board

// ==== verification/strap_config_latch_tb.sv ====
// Self-checking bench for the strap loader over many reset cycles.
// Assumes the board model and the bound checker are compiled beside it.
`timescale 1ns/1ns
module strap_config_latch_tb;
	import scl_pkg::*;
	logic core_clk, rstn, reg_wr, reg_rd, cfg_reserved, isolate, an_enable;
	logic an_done, an_speed, an_duplex, op_speed, op_duplex, straps_loaded;
	logic [7:0]  reg_addr, pll_mult, div_125, div_25, div_20;
	logic [15:0] reg_wdata, reg_rdata, st;
	logic [9:0]  strap_in, func_out, pin_out, pin_oe_n, pull_en, pull_up;
	logic [9:0]  board, fitted, s;
	logic [4:0]  station_addr;
	logic [1:0]  ifc_family;
	logic [31:0] lf = 32'ha727d8b4;
	logic        rd_seen = 1'b0;
	scl_mode_t   if_mode, m;
	scl_ref_t    ref_sel;
	logic [15:0] exp_q[$];
	int          num_errors, comparisons;
	strap_config_latch dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .strap_in, .func_out, .pin_out, .pin_oe_n,
		.pull_en, .pull_up, .ifc_family, .an_done, .an_speed, .an_duplex,
		.station_addr, .if_mode, .cfg_reserved, .isolate, .an_enable,
		.op_speed, .op_duplex, .ref_sel, .pll_mult, .div_125, .div_25,
		.div_20, .straps_loaded);
	scl_strap_board u_board (.board, .fitted, .pin_out, .pin_oe_n, .pull_en,
		.pull_up, .pin_lvl(strap_in));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		rd_seen  <= reg_rd;
		lf       <= lfsr(lf);
		func_out <= lf[9:0];
	end
	// Each read result is compared in the cycle after its strobe.
	always @(negedge core_clk) begin
		if (rd_seen === 1'b1)
			check(reg_rdata, exp_q.pop_front());
	end
	initial begin
		repeat (4000) @(posedge core_clk);
		num_errors++;
		final_report();
	end
	initial begin
		{rstn, reg_wr, reg_rd, an_done, an_speed, an_duplex} = '0;
		{reg_addr, reg_wdata, board, ifc_family} = '0;
		fitted = '1;
		for (int i = 0; i < 11; i++) begin
			@(posedge core_clk);
			rstn       <= 1'b0;
			fitted     <= (i == 10) ? 10'h000 : 10'h3ff;
			s = {lf[13:10], (i < 8) ? i[2:0] : lf[2:0], lf[6:4]};
			board      <= s;
			ifc_family <= (i == 8) ? 2'h1 : (i == 9) ? 2'h2 : 2'h0;
			repeat (6) @(posedge core_clk);
			check(16'(pull_en), 16'h03ff);
			check(16'(pin_oe_n), 16'h03ff);
			check(16'(pull_up), 16'h0381);
			check(16'(pin_out), 16'h0000);
			rstn <= 1'b1;
			repeat (3) @(posedge core_clk);
			#1;
			if (i == 10)
				s = 10'h381;
			m = (i == 8) ? SCL_MODE_RMII : (i == 9) ? SCL_MODE_SMII :
				(s[5:3] == 3'h0) ? SCL_MODE_MII : (s[5:3] == 3'h4) ?
				SCL_MODE_PRE : (s[5:3] == 3'h6) ? SCL_MODE_B2B : SCL_MODE_RSVD;
			check(16'(if_mode), 16'(m));
			check(16'(station_addr), {13'h0, s[2:0]});
			st = (i == 8) ? 16'h2 : (i == 9) ? 16'h4 : 16'h1;
			check(16'(ref_sel), st);
			check(16'({isolate, an_enable}), 16'({s[6], s[9]}));
			if (!s[9])
				check(16'({op_speed, op_duplex}), 16'({s[7], s[8]}));
			st = {6'h0, 1'b1, m == SCL_MODE_RSVD, 2'b00, s[2:0], s[5:3]};
			board <= ~s;
			rd(8'h00, {2'b00, s[7], s[9], 1'b0, s[6], 1'b0, s[8], 8'h00});
			rd(8'h04, s[7] ? 16'h01e1 : 16'h0061);
			rd(8'h08, st);
		end
		wr(8'h00, 16'hffff);
		rd(8'h00, 16'h3500);
		wr(8'h04, 16'h0000);
		rd(8'h04, 16'h0001);
		wr(8'h08, 16'hffff);
		rd(8'h08, st);
		rd(8'h10, 16'h0000);
		wr(8'h00, 16'h0000);
		repeat (3) @(posedge core_clk);
		check(16'({op_speed, op_duplex}), 16'h0);
		an_speed  <= 1'b1;
		an_duplex <= 1'b1;
		an_done   <= 1'b1;
		wr(8'h00, 16'h1000);
		repeat (3) @(posedge core_clk);
		check(16'({op_speed, op_duplex}), 16'h3);
		check(16'(exp_q.size()), 16'h0);
		final_report();
	end
endmodule : strap_config_latch_tb
